// ### hw/flrc_map.svh
// Overview of operation
// - The device halves the system clock to form the flash input clock before any further division.
// - The device holds the flash clock divider as seven bits, bit 6 the prescale select and the lower six bits the count.
// - After the data register update the host moves the TAP into Run-Test/Idle, and the erase starts only on entering that state.
// - Unsecuring through the backdoor key is allowed only while the backdoor key enable bit is set.
`ifndef FLRC_MAP_SVH
`define FLRC_MAP_SVH
`define FLRC_AW             12
`define FLRC_OFF_CLKDIV     12'h000
`define FLRC_OFF_STATUS     12'h004
`define FLRC_OFF_CONFIG     12'h008
`define FLRC_OFF_KEY        12'h00c
`define FLRC_DIV_W          7
`define FLRC_PRE_BIT        6
`define FLRC_CNT_W          6
`define FLRC_PRE_LAST       3'h7
`define FLRC_CLKDIV_RST     7'h00
`define FLRC_ST_LOADED      0
`define FLRC_ST_BUSY        1
`define FLRC_ST_DONE        2
`define FLRC_ST_SECURED     3
`define FLRC_CFG_BACKDOOR_KEY_ENABLE      0
`define FLRC_CFG_SECURE     1
`endif

// ### hw/flrc_pkg.sv
`default_nettype none
package flrc_pkg;
	typedef enum logic [3:0] {
		FLRC_IDLE  = 4'h1,
		FLRC_ARMED = 4'h2,
		FLRC_ERASE = 4'h4,
		FLRC_DONE  = 4'h8
	} flrc_state_t;

	typedef struct packed {
		logic       prescale;
		logic [5:0] count;
	} flrc_div_t;

	typedef struct packed {
		logic       update;
		logic [6:0] value;
	} flrc_dr_t;
endpackage
`default_nettype wire

// ### hw/flrc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "flrc_map.svh"
module flrc_top
	import flrc_pkg::*;
#(
	parameter int          ERASE_TICKS  = 16,
	parameter logic [31:0] BACKDOOR_KEY = 32'h5a5a_c3c3, // Arbitrary value.
	parameter logic        SECURE_RST   = 1'b1
) (
	// Clock and reset.
	input  wire logic        SYS_CLK,
	input  wire logic        ARST_N,
	// APB slave.
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic [31:0]      PRDATA,
	// TAP side, already in the system clock domain.
	input  wire logic        JTAG_RECOVERY_IR,
	input  wire flrc_dr_t    JTAG_DR,
	input  wire logic        JTAG_RUN_IDLE,
	// Flash timing and erase control.
	output logic             FLASH_TIMING_TICK,
	output logic             FLASH_ERASE_BUSY,
	output logic             FLASH_ERASE_DONE,
	output logic             FLASH_SECURED
);
	logic        setup;
	logic        access;
	logic        mapped;
	logic        wr_div;
	logic        wr_cfg;
	logic        wr_key;
	flrc_div_t   clkdiv_q,  clkdiv_d;
	logic [1:0]  cfg_q,     cfg_d;
	logic        secured_q, secured_d;
	logic [31:0] prdata_q,  prdata_d;
	logic        half_q,    half_d;
	logic [2:0]  pre_q,     pre_d;
	logic [5:0]  cnt_q,     cnt_d;
	logic        in_tick;
	logic        pre_tick;
	logic        tick;
	flrc_div_t   active;
	flrc_div_t   dr_div_q,  dr_div_d;
	flrc_state_t st_q,      st_d;
	logic        rti_q;
	logic        rti_enter;
	logic        erase_go;
	logic [15:0] ers_q,     ers_d;
	logic        key_ok;

	// APB decode; the slave never inserts wait states.
	assign setup  = PSEL && !PENABLE;
	assign access = PSEL && PENABLE;
	assign mapped = (PADDR == `FLRC_OFF_CLKDIV) || (PADDR == `FLRC_OFF_STATUS) ||
			(PADDR == `FLRC_OFF_CONFIG) || (PADDR == `FLRC_OFF_KEY);
	assign PREADY  = access;
	assign PSLVERR = access && !mapped;
	assign PRDATA  = prdata_q;
	assign wr_div  = access && PWRITE && (PADDR == `FLRC_OFF_CLKDIV);
	assign wr_cfg  = access && PWRITE && (PADDR == `FLRC_OFF_CONFIG);
	assign wr_key  = access && PWRITE && (PADDR == `FLRC_OFF_KEY);
	assign key_ok  = wr_key && cfg_q[`FLRC_CFG_BACKDOOR_KEY_ENABLE] && (PWDATA == BACKDOOR_KEY);

	always_comb begin
		clkdiv_d  = clkdiv_q;
		cfg_d     = cfg_q;
		secured_d = secured_q;
		prdata_d  = prdata_q;
		if (wr_div) begin
			clkdiv_d = flrc_div_t'(PWDATA[`FLRC_DIV_W-1:0]);
		end
		if (wr_cfg) begin
			cfg_d = PWDATA[1:0];
			if (PWDATA[`FLRC_CFG_SECURE]) begin
				secured_d = 1'b1;
			end
		end
		// An unlock in the same cycle as a secure write wins, so the key is never lost.
		if (key_ok || (st_q == FLRC_ERASE && st_d == FLRC_DONE)) begin
			secured_d = 1'b0;
		end
		if (setup) begin
			prdata_d = 32'h0000_0000;
			unique case (PADDR)
				`FLRC_OFF_CLKDIV: prdata_d[`FLRC_DIV_W-1:0] = clkdiv_q;
				`FLRC_OFF_STATUS: prdata_d[3:0] = {secured_q, st_q == FLRC_DONE,
						st_q == FLRC_ERASE, st_q == FLRC_ARMED};
				`FLRC_OFF_CONFIG: prdata_d[1:0] = cfg_q;
				default:          prdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			clkdiv_q  <= flrc_div_t'(`FLRC_CLKDIV_RST);
			cfg_q     <= 2'h0;
			secured_q <= SECURE_RST;
			prdata_q  <= 32'h0000_0000;
		end else begin
			clkdiv_q  <= clkdiv_d;
			cfg_q     <= cfg_d;
			secured_q <= secured_d;
			prdata_q  <= prdata_d;
		end
	end

	// Timing clock: halve, optionally divide by eight, then divide by count plus one.
	// During recovery the divider value from the TAP drives it, as software cannot run then.
	assign active   = (st_q == FLRC_IDLE) ? clkdiv_q : dr_div_q;
	assign in_tick  = half_q;
	assign pre_tick = in_tick && (!active.prescale || pre_q == `FLRC_PRE_LAST);
	assign tick     = pre_tick && (cnt_q == active.count);
	assign FLASH_TIMING_TICK = tick;

	always_comb begin
		half_d = !half_q;
		pre_d  = in_tick ? pre_q + 3'h1 : pre_q;
		cnt_d  = cnt_q;
		if (pre_tick) begin
			cnt_d = tick ? 6'h00 : cnt_q + 6'h01;
		end
		// The chain restarts as an erase begins. A counter left above a smaller recovery
		// count would otherwise run up to its top and wrap, stretching the erase by many periods.
		if (erase_go) begin
			half_d = 1'b0;
			pre_d  = 3'h0;
			cnt_d  = 6'h00;
		end
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			half_q <= 1'b0;
			pre_q  <= 3'h0;
			cnt_q  <= 6'h00;
		end else begin
			half_q <= half_d;
			pre_q  <= pre_d;
			cnt_q  <= cnt_d;
		end
	end

	// Recovery sequence. Leaving Run-Test/Idle early is the host's fault and does not abort.
	assign rti_enter = JTAG_RUN_IDLE && !rti_q;
	assign erase_go  = (st_q == FLRC_ARMED) && (st_d == FLRC_ERASE);

	always_comb begin
		st_d     = st_q;
		dr_div_d = dr_div_q;
		ers_d    = ers_q;
		unique case (st_q)
			FLRC_IDLE, FLRC_ARMED: begin
				if (JTAG_RECOVERY_IR && JTAG_DR.update) begin
					dr_div_d = flrc_div_t'(JTAG_DR.value);
					st_d     = FLRC_ARMED;
				end else if (st_q == FLRC_ARMED && rti_enter) begin
					st_d  = FLRC_ERASE;
					ers_d = 16'h0000;
				end
			end
			FLRC_ERASE: begin
				if (tick) begin
					ers_d = ers_q + 16'h0001;
					if (ers_q == 16'(ERASE_TICKS - 1)) begin
						st_d = FLRC_DONE;
					end
				end
			end
			// Only a chip reset leaves DONE, matching the required reset after recovery.
			FLRC_DONE: st_d = FLRC_DONE;
			default:   st_d = FLRC_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_q     <= FLRC_IDLE;
			dr_div_q <= flrc_div_t'(`FLRC_CLKDIV_RST);
			ers_q    <= 16'h0000;
			rti_q    <= 1'b0;
		end else begin
			st_q     <= st_d;
			dr_div_q <= dr_div_d;
			ers_q    <= ers_d;
			rti_q    <= JTAG_RUN_IDLE;
		end
	end

	assign FLASH_ERASE_BUSY = (st_q == FLRC_ERASE);
	assign FLASH_ERASE_DONE = (st_q == FLRC_DONE);
	assign FLASH_SECURED    = secured_q;

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);

	half_rate_a: assert property (in_tick |=> !in_tick)
		else $error("flash input tick not at half rate");
	tick_source_a: assert property (tick |-> in_tick)
		else $error("timing tick without input tick");
	prescale_div_a: assert property (tick && active.prescale |-> pre_q == 3'h7)
		else $error("prescale by eight skipped");
	count_match_a: assert property (tick |-> cnt_q == active.count ##1 cnt_q == 6'h00)
		else $error("timing tick at wrong count");
	div_write_a: assert property (wr_div |=> clkdiv_q == $past(PWDATA[6:0]))
		else $error("divider write not held");
	erase_start_a: assert property ($rose(st_q == FLRC_ERASE) |->
			$past(st_q) == FLRC_ARMED && $past(JTAG_RUN_IDLE) && !$past(rti_q))
		else $error("erase started outside Run-Test/Idle entry");
	key_gate_a: assert property ($fell(secured_q) |->
			$past(cfg_q[0]) || $past(st_q) == FLRC_ERASE)
		else $error("unsecured without key enable or erase");
	erase_len_a: assert property ($rose(st_q == FLRC_DONE) |-> $past(ers_q) == 16'(ERASE_TICKS - 1))
		else $error("erase ended early");
	unmapped_a: assert property (access && !mapped |-> PSLVERR && PREADY)
		else $error("unmapped access not flagged");

	erase_run_c: cover property ($rose(st_q == FLRC_DONE));
	key_unlock_c: cover property (key_ok ##1 !secured_q);
	prescale_c: cover property (tick && active.prescale);
	unmapped_c: cover property (access && !mapped);
endmodule
`default_nettype wire

// ### tb/flrc_jtag_host.sv
`timescale 1ns/1ns
`default_nettype none
module flrc_jtag_host
	import flrc_pkg::*;
(
	// Bench control.
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [6:0] val,
	input  wire logic       done,
	// TAP side.
	output logic            ir,
	output flrc_dr_t        dr,
	output logic            rti
);
	initial begin
		ir = 1'b0;
		rti = 1'b0;
		dr = '0;
	end
	// A released data register shows the inverse so a stale value cannot pass.
	always @(posedge go) begin
		@(posedge clk);
		ir <= 1'b1;
		@(posedge clk);
		dr <= '{1'b1, val};
		@(posedge clk);
		dr <= '{1'b0, ~val};
		rti <= 1'b1;
		wait (done === 1'b1);
		@(posedge clk);
		rti <= 1'b0;
		ir <= 1'b0;
	end
endmodule
`default_nettype wire

// ### tb/flash_lockout_recovery_clkdiv_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module flash_lockout_recovery_clkdiv_tb_top
	import flrc_pkg::*;
;
	localparam logic [31:0] KEY = 32'h1234_abcd; // Arbitrary value.
	localparam int ERASE_T = 2;
	localparam logic [6:0] DR_VAL = 7'h01;
	// An erase lasts ERASE_T timing periods, each twice the recovery count plus one.
	localparam int ERASE_CYC = ERASE_T * 2 * (int'(DR_VAL[5:0]) + 1);
	logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic pready, pslverr, tick, busy, done, secured, ir, rti, e;
	flrc_dr_t dr;
	int bad_count = 0, samples_checked = 0, cyc = 0, n;
	always #5 clk = ~clk;
	flrc_top #(.ERASE_TICKS(ERASE_T), .BACKDOOR_KEY(KEY)) i_dut (.SYS_CLK(clk), .ARST_N(arst_n),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata), .JTAG_RECOVERY_IR(ir), .JTAG_DR(dr),
		.JTAG_RUN_IDLE(rti), .FLASH_TIMING_TICK(tick), .FLASH_ERASE_BUSY(busy),
		.FLASH_ERASE_DONE(done), .FLASH_SECURED(secured));
	flrc_jtag_host i_host (.clk(clk), .go(go), .val(DR_VAL), .done(done), .ir(ir), .dr(dr), .rti(rti));
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			test_done();
		end
	end
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic rst();
		arst_n <= 1'b0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
	endtask
	task automatic period(output int p);
		p = 0;
		repeat (2) begin
			p = 0;
			do begin
				@(posedge clk);
				p++;
			end while (tick !== 1'b1);
		end
	endtask
	task automatic test_regs();
		apb(1'b0, 12'h000, 32'h0);
		chk("clkdiv_rst", 32'h0, r);
		chk("mapped_err", 32'h0, e);
		apb(1'b0, 12'h004, 32'h0);
		chk("status_rst", 32'h8, r);
		apb(1'b1, 12'h000, 32'hffff_ffff);
		apb(1'b0, 12'h000, 32'h0);
		chk("clkdiv_width", 32'h7f, r);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped_err", 32'h1, e);
		chk("unmapped_data", 32'h0, r);
		$display("registers done");
	endtask
	task automatic test_divider();
		// Small counts keep the run short; real setups aim at 150 to 200 kHz.
		apb(1'b1, 12'h000, 32'h02);
		period(n);
		chk("tick_half", 32'h6, n);
		apb(1'b1, 12'h000, 32'h41);
		period(n);
		chk("tick_pre8", 32'h20, n);
		$display("divider done");
	endtask
	task automatic test_backdoor();
		apb(1'b1, 12'h008, 32'h0);
		apb(1'b1, 12'h00c, KEY);
		@(posedge clk);
		chk("key_disabled", 32'h1, secured);
		apb(1'b1, 12'h008, 32'h1);
		apb(1'b1, 12'h00c, ~KEY);
		@(posedge clk);
		chk("key_wrong", 32'h1, secured);
		apb(1'b1, 12'h00c, KEY);
		@(posedge clk);
		chk("key_right", 32'h0, secured);
		apb(1'b1, 12'h008, 32'h3);
		@(posedge clk);
		chk("secure_set", 32'h1, secured);
		rst();
		$display("backdoor done");
	endtask
	task automatic test_recovery();
		apb(1'b1, 12'h000, 32'h05);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do @(posedge clk); while (rti !== 1'b1);
		chk("busy_early", 32'h0, busy);
		n = 0;
		while (busy !== 1'b1 && n < 3) begin
			@(posedge clk);
			n++;
		end
		chk("busy_start", 32'h1, busy);
		n = 0;
		while (busy === 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk("erase_len", ERASE_CYC, n);
		chk("erase_done", 32'h1, done);
		chk("unsecured", 32'h0, secured);
		apb(1'b0, 12'h004, 32'h0);
		chk("status_done", 32'h4, r);
		repeat (3) @(posedge clk);
		rst();
		@(posedge clk);
		chk("secured_back", 32'h1, secured);
		chk("done_clear", 32'h0, done);
		$display("recovery done");
	endtask
	initial begin
		rst();
		test_regs();
		test_divider();
		test_backdoor();
		test_recovery();
		test_done();
	end
endmodule
`default_nettype wire
